//--- logic/ccsr_core.sv
module ccsr_core
  import ccsr_pkg::*;
(
  input  wire logic              mclk_in,
  input  wire logic              rst_in,
  output logic [PC_W-1:0]        pmem_addr_out,
  input  wire logic [15:0]       pmem_data_in,
  output logic [15:0]            instr_out,
  output logic                   instr_valid_out,
  input  wire ccsr_cmd_s         cmd_in,
  output ccsr_dmem_s             dmem_out,
  input  wire logic [7:0]        dmem_rdata_in,
  input  wire logic [IRQ_N-1:0]  irq_req_in,
  output logic                   irq_ack_out,
  output logic [IRQ_W-1:0]       irq_vec_out,
  output logic [7:0]             status_out,
  output logic [7:0]             stack_ptr_out
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  ccsr_state_e     st_q, st_d;
  logic [PC_W-1:0] fpc_q, fpc_d, epc_q, epc_d;
  logic [15:0]     instr_q, instr_d;
  logic            ival_q, ival_d, hold_q, hold_d, ack_q, ack_d, rint_q, rint_d;
  logic [7:0]      status_q, status_d, sp_q, sp_d, rh_q, rh_d, rl_q, rl_d;
  logic [4:0]      ldrd_q, ldrd_d;
  logic [IRQ_W-1:0] vec_q, vec_d, irq_idx;
  ccsr_dmem_s      dmem_q, dmem_d;
  logic [7:0]      rf_q [RF_N];
  logic [7:0]      rf_d [RF_N];
  logic            wa_en, wp_en, take, fire;
  logic [4:0]      wa_adr, wp_adr, ptr_lo;
  logic [7:0]      wa_dat, a_v, b_v, res8, flg, ds_val, st_dat;
  logic [15:0]     wp_dat, res16, pval, pnew, ds_addr;
  logic [8:0]      sum9;
  logic [4:0]      nib5;
  logic [PC_W-1:0] ret_pc;
  logic            ds_reg, ds_stat, ds_stk;

  // ----------------------------------------------------------------
  // Operands, pointers and data-space decode
  // ----------------------------------------------------------------
  assign a_v    = rf_q[cmd_in.rd];
  assign b_v    = rf_q[cmd_in.rr];
  assign ptr_lo = 5'(RF_X_LO + {2'b00, cmd_in.ptr, 1'b0});
  assign pval   = {rf_q[5'(ptr_lo + 5'd1)], rf_q[ptr_lo]};
  assign st_dat = rf_q[cmd_in.rd];

  always_comb
  begin
    case (cmd_in.pmode)
      PM_DISP:    ds_addr = pval + {10'h000, cmd_in.disp};
      PM_PREDEC:  ds_addr = pval - 16'h0001;
      default:    ds_addr = pval;
    endcase
    pnew = (cmd_in.pmode == PM_PREDEC) ? ds_addr : pval + 16'h0001;
    // direct I/O maps onto data space
    if (cmd_in.op == OP_IN || cmd_in.op == OP_OUT)
    begin
      ds_addr = DS_IO_BASE + {10'h000, cmd_in.imm[5:0]};
    end
    // registers at the bottom of data space
    ds_reg  = (ds_addr < DS_IO_BASE);
    ds_stat = (ds_addr == DS_IO_BASE + {10'h000, IO_STATUS});
    // only the low stack byte exists
    ds_stk  = (ds_addr == DS_IO_BASE + {10'h000, IO_STACK_PTR});
    ds_val  = ds_reg ? rf_q[ds_addr[4:0]] : (ds_stat ? status_q : sp_q);
  end

  // ----------------------------------------------------------------
  // Interrupt priority
  // ----------------------------------------------------------------
  always_comb
  begin
    irq_idx = '0;
    for (int k = IRQ_N - 1; k >= 0; k--)
    begin
      if (irq_req_in[k])
      begin
        irq_idx = IRQ_W'(k);
      end
    end
  end

  // ----------------------------------------------------------------
  // ALU and flags
  // ----------------------------------------------------------------
  always_comb
  begin
    sum9  = 9'h000;
    nib5  = 5'h00;
    res8  = 8'h00;
    res16 = 16'h0000;
    flg   = status_q;
    case (cmd_in.op)
      OP_ADD, OP_ADC:
      begin
        nib5 = {1'b0, a_v[3:0]} + {1'b0, b_v[3:0]} +
               {4'h0, (cmd_in.op == OP_ADC) & status_q[SB_C]};
        sum9 = {1'b0, a_v} + {1'b0, b_v} + {8'h00, (cmd_in.op == OP_ADC) & status_q[SB_C]};
        res8 = sum9[7:0];
        flg[SB_H] = nib5[4];
        flg[SB_V] = (a_v[7] == b_v[7]) && (res8[7] != a_v[7]);
        flg[SB_C] = sum9[8];
      end
      OP_SUB:
      begin
        nib5 = {1'b0, a_v[3:0]} - {1'b0, b_v[3:0]};
        sum9 = {1'b0, a_v} - {1'b0, b_v};
        res8 = sum9[7:0];
        flg[SB_H] = nib5[4];
        flg[SB_V] = (a_v[7] != b_v[7]) && (res8[7] != a_v[7]);
        flg[SB_C] = sum9[8];
      end
      OP_AND, OP_OR, OP_EOR:
      begin
        res8 = (cmd_in.op == OP_AND) ? (a_v & b_v) :
               (cmd_in.op == OP_OR)  ? (a_v | b_v) : (a_v ^ b_v);
        flg[SB_V] = 1'b0;
      end
      OP_INC:
      begin
        res8 = a_v + 8'h01;
        flg[SB_V] = (res8 == 8'h80);
      end
      OP_MOV:
        res8 = b_v;
      // bit load from the copy store
      OP_COPY_FROM_FLAG:
      begin
        res8 = a_v;
        res8[cmd_in.bsel] = status_q[SB_T];
      end
      // bit store into the copy store
      OP_COPY_TO_FLAG:
        flg[SB_T] = a_v[cmd_in.bsel];
      OP_MUL:
      begin
        res16 = {8'h00, a_v} * {8'h00, b_v};
        flg[SB_C] = res16[15];
        flg[SB_Z] = (res16 == 16'h0000);
      end
      OP_ADIW:
      begin
        res16 = {rf_q[5'(cmd_in.rd + 5'd1)], a_v} + {10'h000, cmd_in.imm[5:0]};
        flg[SB_V] = ~rf_q[5'(cmd_in.rd + 5'd1)][7] & res16[15];
        flg[SB_C] = rf_q[5'(cmd_in.rd + 5'd1)][7] & ~res16[15];
        flg[SB_N] = res16[15];
        flg[SB_Z] = (res16 == 16'h0000);
      end
      OP_MOVW:
        res16 = {rf_q[5'(cmd_in.rr + 5'd1)], b_v};
      default:
        ;
    endcase
    if (cmd_in.op inside {OP_ADD, OP_ADC, OP_SUB, OP_AND, OP_OR, OP_EOR, OP_INC})
    begin
      flg[SB_N] = res8[7];
      flg[SB_Z] = (res8 == 8'h00);
    end
    flg[SB_S] = flg[SB_N] ^ flg[SB_V];
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    st_d = st_q;     fpc_d = fpc_q;     instr_d = instr_q;  ival_d = ival_q;
    epc_d = epc_q;   status_d = status_q; sp_d = sp_q;      dmem_d = '0;
    ldrd_d = ldrd_q; rh_d = rh_q;       rl_d = rl_q;        hold_d = hold_q;
    ack_d = 1'b0;    vec_d = vec_q;     rint_d = rint_q;
    wa_en = 1'b0;    wa_adr = cmd_in.rd; wa_dat = res8;
    wp_en = 1'b0;    wp_adr = cmd_in.rd; wp_dat = res16;
    take = 1'b0;     fire = 1'b0;
    ret_pc = ival_q ? epc_q : fpc_q;
    case (st_q)
      ST_RUN:
      begin
        take = status_q[SB_I] && (|irq_req_in) && !hold_q;
        fire = ival_q && !take;
        fpc_d   = PC_W'(fpc_q + 1'b1);
        instr_d = pmem_data_in;
        ival_d  = 1'b1;
        epc_d   = fpc_q;
        if (take)
        begin
          // entry clears enable; status is left alone otherwise
          status_d[SB_I] = 1'b0;
          dmem_d = '{addr: {8'h00, sp_q}, we: 1'b1, re: 1'b0, wdata: ret_pc[7:0]};
          rh_d   = 8'(ret_pc >> 8);
          sp_d   = sp_q - 8'h02;
          fpc_d  = PC_W'(irq_idx) + PC_W'(1);
          ival_d = 1'b0;
          ack_d  = 1'b1;
          vec_d  = irq_idx;
          st_d   = ST_PUSH2;
        end
        else if (fire)
        begin
          hold_d = 1'b0;
          case (cmd_in.op)
            OP_ADD, OP_ADC, OP_SUB, OP_AND, OP_OR, OP_EOR, OP_INC, OP_MOV,
            OP_COPY_FROM_FLAG:
            begin
              wa_en = 1'b1;
              status_d = flg;
            end
            OP_COPY_TO_FLAG:
              status_d = flg;
            OP_MUL, OP_ADIW, OP_MOVW:
            begin
              wp_en    = 1'b1;
              wp_adr   = (cmd_in.op == OP_MUL) ? 5'h00 : cmd_in.rd;
              status_d = flg;
            end
            OP_GIE_SET:
            begin
              status_d[SB_I] = 1'b1;
              hold_d = 1'b1;
            end
            OP_GIE_CLR:
              status_d[SB_I] = 1'b0;
            OP_PUSH:
            begin
              dmem_d = '{addr: {8'h00, sp_q}, we: 1'b1, re: 1'b0, wdata: st_dat};
              sp_d   = sp_q - 8'h01;
            end
            OP_POP:
            begin
              dmem_d = '{addr: {8'h00, 8'(sp_q + 8'h01)}, we: 1'b0, re: 1'b1, wdata: 8'h00};
              sp_d   = sp_q + 8'h01;
              ldrd_d = cmd_in.rd;
              st_d   = ST_LOAD;
            end
            OP_CALL:
            begin
              dmem_d = '{addr: {8'h00, sp_q}, we: 1'b1, re: 1'b0, wdata: fpc_q[7:0]};
              rh_d   = 8'(fpc_q >> 8);
              sp_d   = sp_q - 8'h02;
              fpc_d  = cmd_in.target;
              ival_d = 1'b0;
              st_d   = ST_PUSH2;
            end
            OP_JUMP:
            begin
              fpc_d  = cmd_in.target;
              ival_d = 1'b0;
            end
            OP_RETURN_SUB, OP_RETURN_INT:
            begin
              dmem_d = '{addr: {8'h00, 8'(sp_q + 8'h01)}, we: 1'b0, re: 1'b1, wdata: 8'h00};
              fpc_d  = fpc_q;
              ival_d = 1'b0;
              rint_d = (cmd_in.op == OP_RETURN_INT);
              st_d   = ST_POP1;
            end
            OP_LD, OP_IN:
            begin
              if (cmd_in.op == OP_LD && cmd_in.pmode != PM_DISP)
              begin
                wp_en  = 1'b1;
                wp_adr = ptr_lo;
                wp_dat = pnew;
              end
              if (ds_reg || ds_stat || ds_stk)
              begin
                wa_en  = 1'b1;
                wa_dat = ds_val;
              end
              else
              begin
                dmem_d = '{addr: ds_addr, we: 1'b0, re: 1'b1, wdata: 8'h00};
                ldrd_d = cmd_in.rd;
                st_d   = ST_LOAD;
              end
            end
            OP_ST, OP_OUT:
            begin
              if (cmd_in.op == OP_ST && cmd_in.pmode != PM_DISP)
              begin
                wp_en  = 1'b1;
                wp_adr = ptr_lo;
                wp_dat = pnew;
              end
              if (ds_reg)
              begin
                wa_en  = 1'b1;
                wa_adr = ds_addr[4:0];
                wa_dat = st_dat;
              end
              else if (ds_stat)
              begin
                // sign stays consistent after a direct write
                status_d = {st_dat[7:5], st_dat[2] ^ st_dat[3], st_dat[3:0]};
              end
              else if (ds_stk)
              begin
                sp_d = st_dat;
              end
              else
              begin
                dmem_d = '{addr: ds_addr, we: 1'b1, re: 1'b0, wdata: st_dat};
              end
            end
            default:
              ;
          endcase
        end
      end
      ST_LOAD:
      begin
        wa_en  = 1'b1;
        wa_adr = ldrd_q;
        wa_dat = dmem_rdata_in;
        st_d   = ST_RUN;
      end
      ST_PUSH2:
      begin
        dmem_d = '{addr: {8'h00, 8'(sp_q + 8'h01)}, we: 1'b1, re: 1'b0, wdata: rh_q};
        st_d   = ST_RUN;
      end
      ST_POP1:
      begin
        rh_d   = dmem_rdata_in;
        dmem_d = '{addr: {8'h00, 8'(sp_q + 8'h02)}, we: 1'b0, re: 1'b1, wdata: 8'h00};
        st_d   = ST_POP2;
      end
      ST_POP2:
      begin
        rl_d = dmem_rdata_in;
        st_d = ST_POP3;
      end
      ST_POP3:
      begin
        // fourth cycle restores flow, and enable on an interrupt return
        fpc_d = PC_W'({rh_q, rl_q});
        // return raises the pointer by two
        sp_d  = sp_q + 8'h02;
        if (rint_q)
        begin
          status_d[SB_I] = 1'b1;
          hold_d = 1'b1;
        end
        st_d = ST_RUN;
      end
      default:
        st_d = ST_RUN;
    endcase
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  // A sixteen-bit write takes precedence over the byte port on the same entry.
  for (genvar gi = 0; gi < RF_N; gi++)
  begin : g_rf
    always_comb
    begin
      rf_d[gi] = rf_q[gi];
      if (wp_en && wp_adr == 5'(gi))
      begin
        rf_d[gi] = wp_dat[7:0];
      end
      else if (wp_en && 5'(wp_adr + 5'd1) == 5'(gi))
      begin
        rf_d[gi] = wp_dat[15:8];
      end
      else if (wa_en && wa_adr == 5'(gi))
      begin
        rf_d[gi] = wa_dat;
      end
    end
    always_ff @(posedge mclk_in)
    begin
      rf_q[gi] <= rf_d[gi];
    end
  end

  // every flop runs on the undivided clock
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      st_q <= ST_RUN;   fpc_q <= '0;   epc_q <= '0;  instr_q <= 16'h0000;
      ival_q <= 1'b0;   hold_q <= 1'b0; ack_q <= 1'b0; rint_q <= 1'b0;
      status_q <= STATUS_RESET;
      sp_q     <= STACK_PTR_RESET;
      rh_q <= 8'h00;    rl_q <= 8'h00;  ldrd_q <= 5'h00; vec_q <= '0;
      dmem_q <= '0;
    end
    else
    begin
      st_q <= st_d;     fpc_q <= fpc_d; epc_q <= epc_d; instr_q <= instr_d;
      ival_q <= ival_d; hold_q <= hold_d; ack_q <= ack_d; rint_q <= rint_d;
      status_q <= status_d;
      sp_q     <= sp_d;
      rh_q <= rh_d;     rl_q <= rl_d;   ldrd_q <= ldrd_d; vec_q <= vec_d;
      dmem_q <= dmem_d;
    end
  end

  assign pmem_addr_out   = fpc_q;
  assign instr_out       = instr_q;
  assign instr_valid_out = ival_q && st_q == ST_RUN;
  assign dmem_out        = dmem_q;
  assign irq_ack_out     = ack_q;
  assign irq_vec_out     = vec_q;
  assign status_out      = status_q;
  assign stack_ptr_out   = sp_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_PREFETCH: assert property (@(posedge mclk_in) disable iff (rst_in)
    (st_q == ST_RUN && !take && !(fire && cmd_in.op inside {OP_CALL, OP_JUMP,
     OP_RETURN_SUB, OP_RETURN_INT})) |=> pmem_addr_out == PC_W'($past(pmem_addr_out) + 1))
    else $error("Prefetch address did not advance.");
  AST_SIGN: assert property (@(posedge mclk_in) disable iff (rst_in)
    status_q[SB_S] == (status_q[SB_N] ^ status_q[SB_V]))
    else $error("Sign flag differs from negative xor overflow.");
  AST_ZERO_ADD: assert property (@(posedge mclk_in) disable iff (rst_in)
    (fire && cmd_in.op == OP_ADD) |=> status_q[SB_Z] == (rf_q[$past(cmd_in.rd)] == 8'h00))
    else $error("Zero flag does not match the sum.");
  AST_GIE_GATE: assert property (@(posedge mclk_in) disable iff (rst_in)
    !$past(status_q[SB_I]) |-> !irq_ack_out)
    else $error("Interrupt taken while globally disabled.");
  AST_ENTRY: assert property (@(posedge mclk_in) disable iff (rst_in)
    irq_ack_out |-> !status_q[SB_I] && stack_ptr_out == $past(stack_ptr_out) - 8'h02)
    else $error("Interrupt entry left enable set or stack wrong.");
  // The lowest pending request must be the one reported, whichever bits are set.
  AST_PRIO: assert property (@(posedge mclk_in) disable iff (rst_in)
    take |=> ($past(irq_req_in) & ~({IRQ_N{1'b1}} << ({1'b0, irq_vec_out} + 4'd1)))
    == (IRQ_N'(1) << irq_vec_out))
    else $error("Highest priority request not chosen.");
  AST_PUSH: assert property (@(posedge mclk_in) disable iff (rst_in)
    (fire && cmd_in.op == OP_PUSH) |=> stack_ptr_out == $past(stack_ptr_out) - 8'h01)
    else $error("Push did not lower the stack pointer by one.");
  AST_RETURN_INT: assert property (@(posedge mclk_in) disable iff (rst_in)
    (fire && cmd_in.op == OP_RETURN_INT) |=> !status_q[SB_I] [*3] ##1
    (status_q[SB_I] && stack_ptr_out == $past(stack_ptr_out, 4) + 8'h02))
    else $error("Interrupt return timing or stack wrong.");
  AST_RESET: assert property (@(posedge mclk_in) disable iff (rst_in)
    $past(rst_in) |-> stack_ptr_out == STACK_PTR_RESET && status_out == STATUS_RESET)
    else $error("Reset values not loaded.");

  COV_IRQ:  cover property (@(posedge mclk_in) disable iff (rst_in) irq_ack_out);
  COV_RETURN_FROM_INTERRUPT: cover property (@(posedge mclk_in) disable iff (rst_in)
    fire && cmd_in.op == OP_RETURN_INT);
  COV_CALL: cover property (@(posedge mclk_in) disable iff (rst_in)
    fire && cmd_in.op == OP_CALL);
endmodule : ccsr_core

//--- logic/ccsr_pkg.sv
package ccsr_pkg;
  localparam int         PC_W            = 9;
  localparam int         RF_N            = 32;
  localparam int         IRQ_N           = 8;
  localparam int         IRQ_W           = 3;
  localparam logic [7:0] STACK_PTR_RESET = 8'h9f;
  localparam logic [7:0] STATUS_RESET    = 8'h00;
  localparam logic [15:0] DS_IO_BASE     = 16'h0020;
  localparam logic [5:0] IO_STATUS       = 6'h3c;
  localparam logic [5:0] IO_STACK_PTR    = 6'h3b;
  localparam logic [4:0] RF_X_LO         = 5'h1a;
  localparam int         SB_I            = 7;
  localparam int         SB_T            = 6;
  localparam int         SB_H            = 5;
  localparam int         SB_S            = 4;
  localparam int         SB_V            = 3;
  localparam int         SB_N            = 2;
  localparam int         SB_Z            = 1;
  localparam int         SB_C            = 0;

  typedef enum logic [4:0] {
    OP_NOP, OP_ADD, OP_ADC, OP_SUB, OP_AND, OP_OR, OP_EOR, OP_INC, OP_MOV,
    OP_COPY_FROM_FLAG, OP_COPY_TO_FLAG, OP_MUL, OP_ADIW, OP_MOVW, OP_GIE_SET,
    OP_GIE_CLR, OP_PUSH, OP_POP, OP_CALL, OP_JUMP, OP_RETURN_SUB, OP_RETURN_INT,
    OP_LD, OP_ST, OP_IN, OP_OUT
  } ccsr_op_e;

  typedef enum logic [1:0] {PM_DISP, PM_POSTINC, PM_PREDEC} ccsr_pmode_e;

  typedef enum {ST_RUN, ST_LOAD, ST_PUSH2, ST_POP1, ST_POP2, ST_POP3} ccsr_state_e;

  typedef struct packed {
    ccsr_op_e         op;
    logic [4:0]       rd;
    logic [4:0]       rr;
    logic [7:0]       imm;
    logic [2:0]       bsel;
    logic [1:0]       ptr;
    ccsr_pmode_e      pmode;
    logic [5:0]       disp;
    logic [PC_W-1:0]  target;
  } ccsr_cmd_s;

  typedef struct packed {
    logic [15:0] addr;
    logic        we;
    logic        re;
    logic [7:0]  wdata;
  } ccsr_dmem_s;
endpackage : ccsr_pkg

//--- tb/ccsr_mem_model.sv
module ccsr_mem_model
  import ccsr_pkg::*;
(
  input  wire logic            mclk_in,
  input  wire logic [PC_W-1:0] pmem_addr_in,
  output logic [15:0]          pmem_data_out,
  input  wire logic [15:0]     instr_in,
  output ccsr_cmd_s            cmd_out,
  input  wire ccsr_dmem_s      dmem_in,
  output logic [7:0]           rdata_out
);
  timeunit 1ns;
  timeprecision 1ns;
  ccsr_cmd_s  prog [2**PC_W];
  logic [7:0] ram [256];
  logic [7:0] last_q = 8'h00;
  // Each word holds its own address, so the decode table is indexed by it.
  assign pmem_data_out = 16'(pmem_addr_in);
  assign cmd_out = prog[instr_in[PC_W-1:0]];
  // Outside a read the bus shows the inverse of the last value, never a stale copy.
  assign rdata_out = dmem_in.re ? ram[dmem_in.addr[7:0]] : ~last_q;
  // A plain process, since the bench preloads the same arrays at time zero.
  always @(posedge mclk_in)
  begin
    if (dmem_in.re)
      last_q <= ram[dmem_in.addr[7:0]];
    if (dmem_in.we)
      ram[dmem_in.addr[7:0]] <= dmem_in.wdata;
  end
endmodule : ccsr_mem_model

//--- tb/cpu_core_state_registers_tb.sv
module cpu_core_state_registers_tb
  import ccsr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic             mclk_in = 1'b0;
  logic             rst_in  = 1'b1;
  logic [PC_W-1:0]  pmem_addr;
  logic [15:0]      pmem_data;
  logic [15:0]      instr;
  logic             instr_valid;
  logic             irq_ack;
  ccsr_cmd_s        cmd;
  ccsr_dmem_s       dmem;
  logic [7:0]       rdata;
  logic [7:0]       status;
  logic [7:0]       sp;
  logic [IRQ_N-1:0] irq_req = '0;
  logic [IRQ_W-1:0] irq_vec;
  int               bad_count = 0;
  int               total_checks = 0;

  always #10 mclk_in = ~mclk_in;

  ccsr_core i_dut (.mclk_in(mclk_in), .rst_in(rst_in), .pmem_addr_out(pmem_addr),
    .pmem_data_in(pmem_data), .instr_out(instr), .instr_valid_out(instr_valid),
    .cmd_in(cmd), .dmem_out(dmem), .dmem_rdata_in(rdata), .irq_req_in(irq_req),
    .irq_ack_out(irq_ack), .irq_vec_out(irq_vec), .status_out(status),
    .stack_ptr_out(sp));

  ccsr_mem_model i_mem (.mclk_in(mclk_in), .pmem_addr_in(pmem_addr),
    .pmem_data_out(pmem_data), .instr_in(instr), .cmd_out(cmd), .dmem_in(dmem),
    .rdata_out(rdata));

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : summarize

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : cmp8

  function automatic ccsr_cmd_s mk(input ccsr_op_e op, input logic [4:0] rd,
                                   input logic [4:0] rr, input logic [7:0] io,
                                   input logic [PC_W-1:0] tgt);
    ccsr_cmd_s c;
    c = '0;
    c.op = op;
    c.rd = rd;
    c.rr = rr;
    c.imm = io;
    c.disp = io[5:0];
    c.target = tgt;
    return c;
  endfunction : mk

  // Kind 0: store to 0x22, 1: global enable set, 2: interrupt acknowledge, 3: store to 0x24.
  task automatic wait_until(input int kind);
    for (int n = 0; n < 400; n++)
    begin
      @(negedge mclk_in);
      if (kind == 0 && dmem.we === 1'b1 && dmem.addr === 16'h0022)
        return;
      if (kind == 1 && status[SB_I] === 1'b1)
        return;
      if (kind == 2 && irq_ack === 1'b1)
        return;
      if (kind == 3 && dmem.we === 1'b1 && dmem.addr === 16'h0024)
        return;
    end
    bad_count++;
    $display("MISMATCH %0t wait %0d timed out", $time, kind);
    summarize();
  endtask : wait_until

  task automatic t_reset();
    cmp8(status, 8'h00, "status at reset");
    cmp8(sp, 8'h9f, "stack at reset");
    cmp8({7'h00, instr_valid}, 8'h00, "valid at reset");
  endtask : t_reset

  task automatic t_alu_io();
    wait_until(0);
    cmp8(dmem.wdata, 8'h80, "sum stored");
    cmp8(status, 8'h2c, "flags after add");
    cmp8(sp, 8'h9e, "stack pointer written internally");
  endtask : t_alu_io

  task automatic t_stack();
    wait_until(1);
    cmp8(sp, 8'h9e, "stack after push pop call return");
    cmp8(i_mem.ram[8'h9e], 8'h29, "return low byte");
    cmp8(i_mem.ram[8'h9d], 8'h00, "return high byte");
    cmp8(status, 8'hac, "enable set");
  endtask : t_stack

  task automatic t_irq();
    irq_req = 8'h24;
    wait_until(2);
    cmp8({5'h00, irq_vec}, 8'h02, "lowest request wins");
    cmp8(status, 8'h2c, "entry clears only enable");
    cmp8(sp, 8'h9c, "entry pushes two");
    irq_req = 8'h00;
    wait_until(1);
    cmp8(sp, 8'h9e, "return pops two");
    cmp8(status, 8'hac, "return sets enable only");
  endtask : t_irq

  // Pointer X is walked over r16 and r17, then aimed at data address 0x24.
  task automatic t_pointers();
    wait_until(3);
    cmp8(dmem.wdata, 8'h11, "pointer load store and bit copy");
    cmp8(status, 8'he0, "flags after multiply copy and word add");
  endtask : t_pointers

  initial
  begin
    for (int a = 0; a < 2**PC_W; a++)
      i_mem.prog[a] = '0;
    for (int a = 0; a < 256; a++)
      i_mem.ram[a] = 8'h00;
    i_mem.ram[8'h20] = 8'h7f;
    i_mem.ram[8'h21] = 8'h01;
    i_mem.ram[8'h23] = 8'h9e;
    i_mem.ram[8'h25] = 8'h10;
    i_mem.prog[0] = mk(OP_JUMP, 5'd0, 5'd0, 8'h00, 9'h020);
    i_mem.prog[3] = mk(OP_RETURN_INT, 5'd0, 5'd0, 8'h00, 9'h000);
    i_mem.prog[9'h20] = mk(OP_IN, 5'd20, 5'd20, 8'h03, 9'h000);
    i_mem.prog[9'h21] = mk(OP_OUT, 5'd20, 5'd20, 8'h3b, 9'h000);
    i_mem.prog[9'h22] = mk(OP_IN, 5'd16, 5'd16, 8'h00, 9'h000);
    i_mem.prog[9'h23] = mk(OP_IN, 5'd17, 5'd17, 8'h01, 9'h000);
    i_mem.prog[9'h24] = mk(OP_ADD, 5'd16, 5'd17, 8'h00, 9'h000);
    i_mem.prog[9'h25] = mk(OP_OUT, 5'd16, 5'd16, 8'h02, 9'h000);
    i_mem.prog[9'h26] = mk(OP_PUSH, 5'd16, 5'd16, 8'h00, 9'h000);
    i_mem.prog[9'h27] = mk(OP_POP, 5'd18, 5'd18, 8'h00, 9'h000);
    i_mem.prog[9'h28] = mk(OP_CALL, 5'd0, 5'd0, 8'h00, 9'h040);
    i_mem.prog[9'h29] = mk(OP_GIE_SET, 5'd0, 5'd0, 8'h00, 9'h000);
    i_mem.prog[9'h40] = mk(OP_RETURN_SUB, 5'd0, 5'd0, 8'h00, 9'h000);
    i_mem.prog[9'h2b] = mk(OP_IN, 5'h1a, 5'h1a, 8'h05, 9'h000);
    i_mem.prog[9'h2c] = mk(OP_IN, 5'h1b, 5'h1b, 8'h06, 9'h000);
    i_mem.prog[9'h2d] = mk(OP_LD, 5'h13, 5'h13, 8'h00, 9'h000);
    i_mem.prog[9'h2d].pmode = PM_POSTINC;
    i_mem.prog[9'h2e] = mk(OP_LD, 5'h15, 5'h15, 8'h00, 9'h000);
    i_mem.prog[9'h2e].pmode = PM_POSTINC;
    i_mem.prog[9'h2f] = mk(OP_MUL, 5'h13, 5'h15, 8'h00, 9'h000);
    i_mem.prog[9'h30] = mk(OP_COPY_TO_FLAG, 5'h00, 5'h00, 8'h00, 9'h000);
    i_mem.prog[9'h30].bsel = 3'h7;
    i_mem.prog[9'h31] = mk(OP_COPY_FROM_FLAG, 5'h15, 5'h15, 8'h00, 9'h000);
    i_mem.prog[9'h31].bsel = 3'h4;
    i_mem.prog[9'h32] = mk(OP_ST, 5'h15, 5'h15, 8'h00, 9'h000);
    i_mem.prog[9'h32].pmode = PM_PREDEC;
    i_mem.prog[9'h33] = mk(OP_ADIW, 5'h1a, 5'h1a, 8'h13, 9'h000);
    i_mem.prog[9'h34] = mk(OP_ST, 5'h11, 5'h11, 8'h00, 9'h000);
    repeat (4) @(negedge mclk_in);
    t_reset();
    rst_in = 1'b0;
    t_alu_io();
    t_stack();
    t_irq();
    t_pointers();
    summarize();
  end
endmodule : cpu_core_state_registers_tb
